// File: hw/port_err_regs_cfg.svh
// Offsets, field positions, reset values and fixed codes for the port error/ARI register bank
`ifndef PORT_ERR_REGS_CFG_SVH
`define PORT_ERR_REGS_CFG_SVH
`define OFS_ERR_EN_56      12'hf44
`define OFS_ERR_EN_89      12'hf48
`define OFS_ARI_P0         12'hf50
`define OFS_ARI_P1         12'hf54
`define OFS_ARI_P4         12'hf60
`define OFS_ARI_P5         12'hf64
`define OFS_ARI_P6         12'hf68
`define OFS_ARI_P8         12'hf70
`define OFS_ARI_P9         12'hf74
`define OFS_AER_HDR        12'hfb4
`define OFS_AER_UNC_STAT   12'hfb8
`define OFS_AER_UNC_SEV    12'hfc0
`define OFS_AER_COR_STAT   12'hfc4
`define OFS_AER_COR_MASK   12'hfc8
`define OFS_AER_CAPCTL     12'hfcc
`define OFS_AER_HLOG0      12'hfd0
`define ARI_SUP_BIT        5
`define ARI_EN_BIT         21
`define UNC_DLP_BIT        4
`define UNC_SDN_BIT        5
`define AER_CAP_ID         16'h0001
`define AER_CAP_VER        4'h1
`define AER_NEXT_UP        12'h138
`define AER_NEXT_DN        12'h148
`define ERR_EN_56_MASK     32'h0007_0704
`define ERR_EN_89_MASK     32'h0000_0707
`define UNC_SEV_MASK       32'h003f_9030
`define UNC_SEV_RESET      32'h0006_2030
`define COR_MASK_MASK      32'h0000_31c1
`define COR_MASK_RESET     32'h0000_2000
`define COR_STAT_MASK      32'h0000_31c1
`define CAPCTL_RW_MASK     32'h0000_0140
`define CAPCTL_RO_VAL      32'h0000_00bf
`define NUM_ARI            7
`endif

// File: hw/port_err_regs_pkg.sv
// Types shared by the port error/ARI register bank
package port_err_regs_pkg;
   typedef enum logic [1:0] {
      role_upstream,
      role_downstream,
      role_nt_link,
      role_nt_virtual
   } port_role_type;

   typedef struct packed {
      logic [31:0]      err_en_56;
      logic [31:0]      err_en_89;
      logic [6:0]       ari_en;
      logic [31:0]      unc_stat;
      logic [31:0]      unc_sev;
      logic [31:0]      cor_stat;
      logic [31:0]      cor_mask;
      logic [31:0]      capctl;
      logic [31:0]      rd_data;
      logic             rd_ack;
      logic [1:0]       rst_sync;
      logic [1:0]       dlp_sync;
      logic [1:0]       sdn_sync;
   } bank_state_type;
endpackage

// File: hw/port_err_regs.sv
// Configuration register bank: error-enable shadows, ARI shadows, AER header and status
`timescale 1ns/100ps
`default_nettype none
`include "port_err_regs_cfg.svh"
// Summary of operation
// - Port five error enables at bits 8-10
// - Port six error enables at bits 16-18
// - Ports eight/nine enables at bits 0-2, 8-10
// - Port four fatal bit: factory-test read-write
// - Shadows exist only in ports zero, four, eight
// - Seven ARI shadow words, cap low, control high
// - Bit 5 supported, gated by port capability
// - Bit 21 enable steers Type1-to-Type0 conversion
// - Header reads ID 0001h, version 1h
// - Next pointer 138h upstream, 148h downstream
// - AER block at fixed offsets FB4h-FD0h, FBCh unmapped
// - Data-link protocol error sticky, write-one-clear
// - Surprise-down sticky, downstream only
// - Force-error makes write-one-clear bits plain RW
module port_err_regs
   import port_err_regs_pkg::*;
(
   input  wire logic                 i_clk,
   input  wire logic                 i_arst_n,
   input  wire port_role_type        i_port_role,
   input  wire logic                 i_shadow_present,
   input  wire logic                 i_sw_force_err,
   input  wire logic [6:0]           i_port_ari_cap,
   input  wire logic                 i_dlp_err,
   input  wire logic                 i_surprise_down,
   input  wire logic                 i_cfg_wr,
   input  wire logic                 i_cfg_rd,
   input  wire logic                 i_cfg_load,
   input  wire logic [11:0]          i_cfg_addr,
   input  wire logic [31:0]          i_cfg_wdata,
   input  wire logic [3:0]           i_cfg_be,
   output logic [31:0]               o_cfg_rdata,
   output logic                      o_cfg_rd_ack,
   output logic [6:0]                o_ari_fwd_en,
   output logic [31:0]               o_err_en_56,
   output logic [31:0]               o_err_en_89
);

   bank_state_type state_reg;
   bank_state_type state_next;
   logic           rst_n;
   logic           is_down;
   logic           dlp_evt;
   logic           sdn_evt;
   logic [31:0]    bmask;
   logic [31:0]    unc_wmask;
   logic [31:0]    rd_word;
   logic           wr_any;

   // Offset of the ARI shadow word for a given slot, used by read and write decode
   function automatic logic [11:0] ari_ofs(input int idx);
      case (idx)
         0: ari_ofs = `OFS_ARI_P0;
         1: ari_ofs = `OFS_ARI_P1;
         2: ari_ofs = `OFS_ARI_P4;
         3: ari_ofs = `OFS_ARI_P5;
         4: ari_ofs = `OFS_ARI_P6;
         5: ari_ofs = `OFS_ARI_P8;
         default: ari_ofs = `OFS_ARI_P9;
      endcase
   endfunction

   // Byte-enable expansion to a bit mask
   function automatic logic [31:0] be_mask(input logic [3:0] be);
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   assign rst_n     = state_reg.rst_sync[1];
   assign is_down   = (i_port_role == role_downstream) || (i_port_role == role_nt_virtual);
   assign dlp_evt   = state_reg.dlp_sync[1];
   assign sdn_evt   = state_reg.sdn_sync[1] && is_down;
   assign bmask     = be_mask(i_cfg_be);
   assign wr_any    = i_cfg_wr || i_cfg_load;
   // Writable status bits: surprise-down only on downstream-facing ports
   assign unc_wmask = is_down ? 32'h0000_0030 : 32'h0000_0010;

   // Read multiplexer; unmapped offsets and absent shadows read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (i_shadow_present && (i_cfg_addr == `OFS_ERR_EN_56)) begin
         rd_word = state_reg.err_en_56;
      end else if (i_shadow_present && (i_cfg_addr == `OFS_ERR_EN_89)) begin
         rd_word = state_reg.err_en_89;
      end else if (i_cfg_addr == `OFS_AER_HDR) begin
         rd_word = {(is_down ? `AER_NEXT_DN : `AER_NEXT_UP),
                    `AER_CAP_VER, `AER_CAP_ID};
      end else if (i_cfg_addr == `OFS_AER_UNC_STAT) begin
         rd_word = state_reg.unc_stat & unc_wmask;
      end else if (i_cfg_addr == `OFS_AER_UNC_SEV) begin
         rd_word = state_reg.unc_sev;
      end else if (i_cfg_addr == `OFS_AER_COR_STAT) begin
         rd_word = state_reg.cor_stat;
      end else if (i_cfg_addr == `OFS_AER_COR_MASK) begin
         rd_word = state_reg.cor_mask;
      end else if (i_cfg_addr == `OFS_AER_CAPCTL) begin
         rd_word = state_reg.capctl | `CAPCTL_RO_VAL;
      end else if (i_cfg_addr == `OFS_AER_HLOG0) begin
         rd_word = 32'h0000_0000;                                     // Header capture lies elsewhere
      end else if (i_shadow_present) begin
         for (int k = 0; k < `NUM_ARI; k++) begin
            if (i_cfg_addr == ari_ofs(k)) begin
               rd_word[`ARI_SUP_BIT] = i_port_ari_cap[k];
               rd_word[`ARI_EN_BIT]  = state_reg.ari_en[k];
            end
         end
      end
   end

   // Next-state logic for every register of the bank
   always_comb begin
      state_next          = state_reg;
      state_next.rst_sync = {state_reg.rst_sync[0], 1'b1};
      state_next.dlp_sync = {state_reg.dlp_sync[0], i_dlp_err};
      state_next.sdn_sync = {state_reg.sdn_sync[0], i_surprise_down};
      state_next.rd_ack   = i_cfg_rd;
      state_next.rd_data  = i_cfg_rd ? rd_word : state_reg.rd_data;
      if (wr_any && i_shadow_present) begin
         if (i_cfg_addr == `OFS_ERR_EN_56) begin
            // Reserved bits masked off so they always read zero
            state_next.err_en_56 = (state_reg.err_en_56 & ~(bmask & `ERR_EN_56_MASK))
                                 | (i_cfg_wdata & bmask & `ERR_EN_56_MASK);
         end else if (i_cfg_addr == `OFS_ERR_EN_89) begin
            state_next.err_en_89 = (state_reg.err_en_89 & ~(bmask & `ERR_EN_89_MASK))
                                 | (i_cfg_wdata & bmask & `ERR_EN_89_MASK);
         end
         for (int k = 0; k < `NUM_ARI; k++) begin
            if ((i_cfg_addr == ari_ofs(k)) && i_cfg_be[2]) begin
               state_next.ari_en[k] = i_cfg_wdata[`ARI_EN_BIT];
            end
         end
      end
      if (wr_any) begin
         if (i_cfg_addr == `OFS_AER_UNC_SEV) begin
            state_next.unc_sev = (state_reg.unc_sev & ~(bmask & `UNC_SEV_MASK))
                               | (i_cfg_wdata & bmask & `UNC_SEV_MASK);
         end else if (i_cfg_addr == `OFS_AER_COR_MASK) begin
            state_next.cor_mask = (state_reg.cor_mask & ~(bmask & `COR_MASK_MASK))
                                | (i_cfg_wdata & bmask & `COR_MASK_MASK);
         end else if (i_cfg_addr == `OFS_AER_CAPCTL) begin
            state_next.capctl = (state_reg.capctl & ~(bmask & `CAPCTL_RW_MASK))
                              | (i_cfg_wdata & bmask & `CAPCTL_RW_MASK);
         end else if (i_cfg_addr == `OFS_AER_UNC_STAT) begin
            // Preload and force-error mode write directly; otherwise ones clear
            if (i_sw_force_err || i_cfg_load) begin
               state_next.unc_stat = (state_reg.unc_stat & ~(bmask & unc_wmask))
                                   | (i_cfg_wdata & bmask & unc_wmask);
            end else begin
               state_next.unc_stat = state_reg.unc_stat & ~(i_cfg_wdata & bmask & unc_wmask);
            end
         end else if (i_cfg_addr == `OFS_AER_COR_STAT) begin
            if (i_sw_force_err || i_cfg_load) begin
               state_next.cor_stat = (state_reg.cor_stat & ~(bmask & `COR_STAT_MASK))
                                   | (i_cfg_wdata & bmask & `COR_STAT_MASK);
            end else begin
               state_next.cor_stat = state_reg.cor_stat & ~(i_cfg_wdata & bmask & `COR_STAT_MASK);
            end
         end
      end
      // Hardware set applied last so an event in a clear cycle is kept
      if (dlp_evt) begin
         state_next.unc_stat[`UNC_DLP_BIT] = 1'b1;
      end
      if (sdn_evt) begin
         state_next.unc_stat[`UNC_SDN_BIT] = 1'b1;
      end
   end

   // Single register stage; sticky bits hold across non-fundamental resets
   // because only the fundamental reset reaches this flop
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg          <= '0;
         state_reg.unc_sev  <= `UNC_SEV_RESET;
         state_reg.cor_mask <= `COR_MASK_RESET;
      end else if (!rst_n) begin
         state_reg          <= state_next;
         state_reg.dlp_sync <= 2'b00;
         state_reg.sdn_sync <= 2'b00;
         state_reg.rd_ack   <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_cfg_rdata  = state_reg.rd_data;
   assign o_cfg_rd_ack = state_reg.rd_ack;
   assign o_ari_fwd_en = state_reg.ari_en & {7{i_shadow_present}};
   assign o_err_en_56  = state_reg.err_en_56;
   assign o_err_en_89  = state_reg.err_en_89;

endmodule
`default_nettype wire

// File: dv/port_err_regs_chk.sv
// Port-level assertions for the port error/ARI register bank
`timescale 1ns/100ps
`default_nettype none
module port_err_regs_chk
   import port_err_regs_pkg::*;
(
   input wire logic          i_clk,
   input wire logic          i_arst_n,
   input wire port_role_type i_port_role,
   input wire logic          i_shadow_present,
   input wire logic          i_cfg_wr,
   input wire logic          i_cfg_rd,
   input wire logic [11:0]   i_cfg_addr,
   input wire logic [31:0]   i_cfg_wdata,
   input wire logic [3:0]    i_cfg_be,
   input wire logic [31:0]   o_cfg_rdata,
   input wire logic          o_cfg_rd_ack,
   input wire logic [6:0]    o_ari_fwd_en,
   input wire logic [31:0]   o_err_en_56
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // Header read; role bit 0 selects the downstream next pointer
   sequence s_hdr_rd;
      i_cfg_rd && i_cfg_addr == 12'hfb4;
   endsequence
   a_hdr_value: assert property (s_hdr_rd |=> o_cfg_rdata ==
      {$past(i_port_role[0]) ? 12'h148 : 12'h138, 20'h1_0001}) else $error("bad header");
   a_ack_next: assert property (i_cfg_rd |=> o_cfg_rd_ack) else $error("no ack");
   a_ack_cause: assert property (o_cfg_rd_ack |-> $past(i_cfg_rd)) else $error("stray ack");
   // Data holds between reads so a slow reader still sees one word
   a_rdata_hold: assert property (!$past(i_cfg_rd) |-> $stable(o_cfg_rdata))
      else $error("read data moved");
   a_fwd_gated: assert property (!i_shadow_present [*2] |-> o_ari_fwd_en == 7'h0)
      else $error("enable without shadow");
   a_fwd_write: assert property (i_cfg_wr && i_cfg_addr == 12'hf50 && i_cfg_be[2]
      && i_shadow_present ##1 i_shadow_present |-> o_ari_fwd_en[0] == $past(i_cfg_wdata[21]))
      else $error("enable not written");
   a_err56_write: assert property (
      i_cfg_wr && i_cfg_addr == 12'hf44 && i_cfg_be == 4'hf && i_shadow_present
      |=> o_err_en_56 == ($past(i_cfg_wdata) & 32'h0007_0704)) else $error("bad enables");
   a_unmapped_zero: assert property (i_cfg_rd && i_cfg_addr == 12'hf4c |=>
      o_cfg_rdata == 32'h0) else $error("unmapped read not zero");
endmodule
bind port_err_regs port_err_regs_chk port_err_regs_chk_i (.i_clk, .i_arst_n, .i_port_role,
   .i_shadow_present, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr, .i_cfg_wdata, .i_cfg_be,
   .o_cfg_rdata, .o_cfg_rd_ack, .o_ari_fwd_en, .o_err_en_56);
`default_nettype wire

// File: dv/port_err_regs_test.sv
// Self-checking bench for the port error/ARI register bank
`timescale 1ns/100ps
`default_nettype none
module port_err_regs_test
   import port_err_regs_pkg::*;
;
   logic          i_clk = 1'b0, i_arst_n = 1'b0, i_shadow_present = 1'b1, o_cfg_rd_ack;
   logic          i_sw_force_err = 1'b0, i_dlp_err = 1'b0, i_surprise_down = 1'b0;
   logic          i_cfg_wr = 1'b0, i_cfg_rd = 1'b0, i_cfg_load = 1'b0;
   port_role_type i_port_role = role_upstream;
   logic [6:0]    i_port_ari_cap = 7'h55, o_ari_fwd_en;
   logic [11:0]   i_cfg_addr = 12'h0;
   logic [3:0]    i_cfg_be = 4'hf;
   logic [31:0]   i_cfg_wdata = 32'h0, o_cfg_rdata, o_err_en_56, o_err_en_89;
   int            errors = 0, n_checks = 0;
   // 125 MHz core clock
   always #4 i_clk = ~i_clk;
   port_err_regs port_err_regs_i (.i_clk, .i_arst_n, .i_port_role, .i_shadow_present,
      .i_sw_force_err, .i_port_ari_cap, .i_dlp_err, .i_surprise_down, .i_cfg_wr, .i_cfg_rd,
      .i_cfg_load, .i_cfg_addr, .i_cfg_wdata, .i_cfg_be, .o_cfg_rdata, .o_cfg_rd_ack,
      .o_ari_fwd_en, .o_err_en_56, .o_err_en_89);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One write strobe; ld sends it down the preload path instead
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be,
                     input logic ld);
      @(posedge i_clk);
      {i_cfg_wr, i_cfg_load, i_cfg_addr, i_cfg_wdata, i_cfg_be} <= {!ld, ld, a, d, be};
      @(posedge i_clk);
      {i_cfg_wr, i_cfg_load} <= 2'b00;
   endtask
   // Data is looked at just after the edge that took the read
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge i_clk);
      {i_cfg_rd, i_cfg_addr} <= {1'b1, a};
      @(posedge i_clk);
      i_cfg_rd <= 1'b0;
      #1;
      chk(o_cfg_rdata, exp);
      chk({31'h0, o_cfg_rd_ack}, 32'h1);
   endtask
   // Reset values, masked enables, ARI words, absent shadows
   task automatic t_regs;
      rd(12'hf44, 32'h0);
      rd(12'hfc0, 32'h0006_2030);
      rd(12'hfcc, 32'h0000_00bf);
      rd(12'hf54, 32'h0);
      rd(12'hf4c, 32'h0);
      wr(12'hf44, '1, 4'hf, 1'b0);
      rd(12'hf44, 32'h0007_0704);
      wr(12'hf48, '1, 4'hd, 1'b0);
      rd(12'hf48, 32'h0000_0007);
      chk(o_err_en_89, 32'h0000_0007);
      chk(o_err_en_56, 32'h0007_0704);
      wr(12'hf50, '1, 4'hf, 1'b0);
      wr(12'hf50, 32'h0, 4'hb, 1'b0);
      rd(12'hf50, 32'h0020_0020);
      chk({25'h0, o_ari_fwd_en}, 32'h1);
      i_shadow_present <= 1'b0;
      rd(12'hf44, 32'h0);
      chk({25'h0, o_ari_fwd_en}, 32'h0);
      i_shadow_present <= 1'b1;
   endtask
   // Events set sticky status; writing ones clears it
   task automatic t_events(input port_role_type role, input logic [31:0] hit);
      {i_port_role, i_dlp_err, i_surprise_down} <= {role, 2'b11};
      repeat (3) @(posedge i_clk);
      {i_dlp_err, i_surprise_down} <= 2'b00;
      rd(12'hfb8, hit);
      wr(12'hfb8, 32'h30, 4'hf, 1'b0);
      rd(12'hfb8, 32'h0);
   endtask
   // Next pointer per role, then force-error and preload paths
   task automatic t_roles;
      for (int r = 0; r < 4; r++) begin
         i_port_role <= port_role_type'(r[1:0]);
         rd(12'hfb4, {r[0] ? 12'h148 : 12'h138, 20'h1_0001});
      end
      i_sw_force_err <= 1'b1;
      wr(12'hfb8, 32'h10, 4'hf, 1'b0);
      rd(12'hfb8, 32'h10);
      wr(12'hf48, 32'h0000_0102, 4'hf, 1'b1);
      rd(12'hf48, 32'h0000_0102);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Reset for 12 cycles, leave time for the internal release, then run
   initial begin
      repeat (12) @(posedge i_clk);
      i_arst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      t_regs;
      t_events(role_upstream, 32'h10);
      t_events(role_downstream, 32'h30);
      t_roles;
      tally_and_finish;
   end
   // Watchdog: the sequence needs a few hundred cycles at most
   initial begin
      #20000;
      errors++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
